// ==== design/motor_setup_pkg.sv ====
// shared constants of the motor encoder setup block
package motor_setup_pkg;
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned MEAS_INTERVAL_MS = 100;
    localparam int unsigned MEAS_CYCLES = (CLK_FREQ_HZ / 1000) * MEAS_INTERVAL_MS;
    localparam logic [31:0] RPM_FACTOR = 32'(60000 / MEAS_INTERVAL_MS);

    localparam logic [7:0] ADDR_TOP_SPEED = 8'h00;
    localparam logic [7:0] ADDR_OPTION3 = 8'h04;
    localparam logic [7:0] ADDR_ENC_STEPS = 8'h08;
    localparam logic [7:0] ADDR_ACCEL_TIME = 8'h0C;
    localparam logic [7:0] ADDR_SPEED_LIMIT = 8'h10;
    localparam logic [7:0] ADDR_RAMP_TIME = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_POSITION = 8'h1C;
    localparam logic [7:0] ADDR_SPEED = 8'h20;

    localparam int unsigned OPT_ENC_SWAP_BIT = 0;
    localparam int unsigned OPT_PHASE_SWAP_BIT = 3;
    localparam int unsigned STAT_FAULT_BIT = 0;
    localparam int unsigned STAT_DRIVE_BIT = 1;
    localparam int unsigned STAT_EMREV_BIT = 2;

    localparam logic [15:0] TOP_SPEED_MIN = 16'h01F4;
    localparam logic [15:0] TOP_SPEED_MAX = 16'h1F40;
    localparam logic [15:0] TOP_SPEED_RST = 16'h1770;
    localparam logic [8:0] ENC_STEPS_MIN = 9'h020;
    localparam logic [8:0] ENC_STEPS_MAX = 9'h100;
    localparam logic [8:0] ENC_STEPS_RST = 9'h040;
    localparam logic [15:0] ACCEL_TIME_RST = 16'h0BB8;
    localparam logic [15:0] SPEED_LIMIT_RST = 16'h1770;
    localparam logic [7:0] PARAM_FAULT_CODE = 8'h31;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== design/div_if.sv ====
// request and result signals of a serial divider
`timescale 1ns/10ps
interface div_if #(parameter int W = 32);
    logic start;
    logic [W-1:0] dividend;
    logic [W-1:0] divisor;
    logic busy;
    logic done;
    logic [W-1:0] quotient;
    modport requester (output start, dividend, divisor, input busy, done, quotient);
    modport divider (input start, dividend, divisor, output busy, done, quotient);
endinterface

// ==== design/serial_divider.sv ====
// restoring serial divider, one quotient bit per enabled cycle
`timescale 1ns/10ps
module serial_divider #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    div_if.divider dv
);
    logic [W-1:0] rem_q;
    logic [W-1:0] quo_q;
    logic [W-1:0] den_q;
    logic [$clog2(W+1)-1:0] cnt_q;
    logic [W:0] remShift;

    assign remShift = {rem_q, quo_q[W-1]};
    assign dv.quotient = quo_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rem_q <= '0;
            quo_q <= '0;
            den_q <= '0;
            cnt_q <= '0;
            dv.busy <= 1'b0;
            dv.done <= 1'b0;
        end
        else if (ce)
        begin
            dv.done <= 1'b0;
            if (dv.start && !dv.busy)
            begin
                rem_q <= '0;
                quo_q <= dv.dividend;
                den_q <= dv.divisor;
                cnt_q <= ($clog2(W+1))'(W);
                dv.busy <= 1'b1;
            end
            else if (dv.busy)
            begin
                // a zero divisor yields all ones, never a hang
                if (remShift >= {1'b0, den_q})
                begin
                    rem_q <= W'(remShift - {1'b0, den_q});
                    quo_q <= {quo_q[W-2:0], 1'b1};
                end
                else
                begin
                    rem_q <= remShift[W-1:0];
                    quo_q <= {quo_q[W-2:0], 1'b0};
                end
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == 1)
                begin
                    dv.busy <= 1'b0;
                    dv.done <= 1'b1;
                end
            end
        end
    end
endmodule

// ==== design/motor_encoder_setup.sv ====
// motor encoder setup: settings registers, encoder position and speed, phase routing
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
// Functional notes
// - top speed setting held within 500 to 8000 rpm
// - ramp times scaled by limit over top speed
// - option bit 0 reverses encoder count sense
// - position and speed derived from encoder input
// - emergency reverse relies on forward positive speed
// - option bit 3 exchanges two motor phases
// - encoder resolution 32 to 256 pulses per revolution
// - change of option bit 0, option bit 3 or encoder resolution latches fault 49 until reset
module motor_encoder_setup
    import motor_setup_pkg::*;
#(
    parameter int unsigned MEAS_CYCLES_P = motor_setup_pkg::MEAS_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic encA,
    input wire logic encB,
    input wire logic phaseCmdA,
    input wire logic phaseCmdB,
    input wire logic phaseCmdC,
    input wire logic drivePowered,
    input wire logic emergencyReverse,
    output logic phaseOutA,
    output logic phaseOutB,
    output logic phaseOutC,
    output logic paramFault,
    output logic [7:0] faultCode,
    output logic emRevBrake,
    output logic [15:0] rampTimeMs
);
    import motor_setup_pkg::*;

    logic [15:0] topSpeed_q;
    logic [31:0] optionWord_q;
    logic [8:0] encSteps_q;
    logic [15:0] accelTime_q;
    logic [15:0] speedLimit_q;
    logic [7:0] awAddr_q;
    logic awHeld_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic wHeld_q;
    logic encAPrev_q;
    logic signed [31:0] position_q;
    logic signed [31:0] pulseCount_q;
    logic [31:0] intervalCnt_q;
    logic speedNeg_q;
    logic signed [31:0] speed_q;
    logic doWrite;
    logic [31:0] wrVal;
    logic encEdge;
    logic countUp;
    logic measEnd;
    logic [31:0] absCount;
    logic [15:0] topClamped;
    logic [8:0] stepsClamped;
    logic [31:0] readData;
    logic readHit;

    div_if #(.W(32)) speedDiv ();
    div_if #(.W(32)) rampDiv ();

    serial_divider #(.W(32)) speedDivider (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .dv(speedDiv)
    );
    serial_divider #(.W(32)) rampDivider (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .dv(rampDiv)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction

    // write address and data are taken in either order, answered once both are held
    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

    always_comb
    begin
        wrVal = 32'h0000_0000;
        unique case (awAddr_q)
            ADDR_TOP_SPEED: wrVal = mergeBytes({16'h0000, topSpeed_q}, wData_q, wStrb_q);
            ADDR_OPTION3: wrVal = mergeBytes(optionWord_q, wData_q, wStrb_q);
            ADDR_ENC_STEPS: wrVal = mergeBytes({23'h000000, encSteps_q}, wData_q, wStrb_q);
            ADDR_ACCEL_TIME: wrVal = mergeBytes({16'h0000, accelTime_q}, wData_q, wStrb_q);
            ADDR_SPEED_LIMIT: wrVal = mergeBytes({16'h0000, speedLimit_q}, wData_q, wStrb_q);
            default: wrVal = wData_q;
        endcase
    end

    // out-of-range settings are clamped rather than refused
    always_comb
    begin
        if (wrVal[15:0] < TOP_SPEED_MIN)
            topClamped = TOP_SPEED_MIN;
        else if (wrVal[15:0] > TOP_SPEED_MAX)
            topClamped = TOP_SPEED_MAX;
        else
            topClamped = wrVal[15:0];
        if (wrVal[31:9] != 23'h000000 || wrVal[8:0] > ENC_STEPS_MAX)
            stepsClamped = ENC_STEPS_MAX;
        else if (wrVal[8:0] < ENC_STEPS_MIN)
            stepsClamped = ENC_STEPS_MIN;
        else
            stepsClamped = wrVal[8:0];
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            awHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            s_axi_awready <= 1'b0;
            wHeld_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_awready <= !awHeld_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !wHeld_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite)
            begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (awAddr_q)
                    ADDR_TOP_SPEED, ADDR_OPTION3, ADDR_ENC_STEPS, ADDR_ACCEL_TIME,
                    ADDR_SPEED_LIMIT, ADDR_RAMP_TIME, ADDR_STATUS, ADDR_POSITION,
                    ADDR_SPEED: s_axi_bresp <= RESP_OKAY;
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            topSpeed_q <= TOP_SPEED_RST;
            optionWord_q <= 32'h0000_0000;
            encSteps_q <= ENC_STEPS_RST;
            accelTime_q <= ACCEL_TIME_RST;
            speedLimit_q <= SPEED_LIMIT_RST;
        end
        else if (ce && doWrite)
        begin
            unique case (awAddr_q)
                ADDR_TOP_SPEED: topSpeed_q <= topClamped;
                ADDR_OPTION3: optionWord_q <= wrVal;
                ADDR_ENC_STEPS: encSteps_q <= stepsClamped;
                ADDR_ACCEL_TIME: accelTime_q <= wrVal[15:0];
                ADDR_SPEED_LIMIT: speedLimit_q <= wrVal[15:0];
                default: ;
            endcase
        end
    end

    a_top_range: assert property (topSpeed_q >= TOP_SPEED_MIN && topSpeed_q <= TOP_SPEED_MAX)
        else $error("top speed left its range");
    a_steps_range: assert property (encSteps_q >= ENC_STEPS_MIN && encSteps_q <= ENC_STEPS_MAX)
        else $error("encoder resolution left its range");

    // only a reset, standing for a power cycle, clears the fault
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            paramFault <= 1'b0;
            faultCode <= 8'h00;
        end
        else if (ce && doWrite)
        begin
            if ((awAddr_q == ADDR_OPTION3 &&
                 (wrVal[OPT_ENC_SWAP_BIT] != optionWord_q[OPT_ENC_SWAP_BIT] ||
                  wrVal[OPT_PHASE_SWAP_BIT] != optionWord_q[OPT_PHASE_SWAP_BIT])) ||
                (awAddr_q == ADDR_ENC_STEPS && stepsClamped != encSteps_q))
            begin
                paramFault <= 1'b1;
                faultCode <= PARAM_FAULT_CODE;
            end
        end
    end

    a_fault_sticky: assert property (paramFault |=> paramFault && faultCode == 8'h31)
        else $error("parameter fault dropped");
    a_fault_on_change: assert property (ce && doWrite && awAddr_q == ADDR_ENC_STEPS &&
        stepsClamped != encSteps_q |=> paramFault)
        else $error("resolution change without fault");

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            phaseOutA <= 1'b0;
            phaseOutB <= 1'b0;
            phaseOutC <= 1'b0;
        end
        else if (ce)
        begin
            phaseOutA <= phaseCmdA;
            phaseOutB <= optionWord_q[OPT_PHASE_SWAP_BIT] ? phaseCmdC : phaseCmdB;
            phaseOutC <= optionWord_q[OPT_PHASE_SWAP_BIT] ? phaseCmdB : phaseCmdC;
        end
    end

    a_phase_swap: assert property (ce && optionWord_q[OPT_PHASE_SWAP_BIT] |=>
        phaseOutB == $past(phaseCmdC) && phaseOutC == $past(phaseCmdB))
        else $error("phases not exchanged");

    // one count per rising edge of channel A; channel B gives the sense
    assign encEdge = encA && !encAPrev_q;
    assign countUp = !encB ^ optionWord_q[OPT_ENC_SWAP_BIT];
    assign measEnd = (intervalCnt_q == 32'(MEAS_CYCLES_P - 1));

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            encAPrev_q <= 1'b0;
            position_q <= 32'sh0;
        end
        else if (ce)
        begin
            encAPrev_q <= encA;
            if (encEdge)
                position_q <= countUp ? position_q + 1 : position_q - 1;
        end
    end

    a_enc_dir: assert property (ce && encEdge && !encB && optionWord_q[OPT_ENC_SWAP_BIT] |=>
        position_q == $past(position_q) - 1)
        else $error("swapped encoder counted forward");

    // an edge in the closing cycle opens the next window, so none is lost
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            intervalCnt_q <= 32'h0000_0000;
            pulseCount_q <= 32'sh0;
        end
        else if (ce)
        begin
            intervalCnt_q <= measEnd ? 32'h0000_0000 : intervalCnt_q + 1;
            if (measEnd)
                pulseCount_q <= encEdge ? (countUp ? 32'sh1 : -32'sh1) : 32'sh0;
            else if (encEdge)
                pulseCount_q <= countUp ? pulseCount_q + 1 : pulseCount_q - 1;
        end
    end

    a_pulse_count: assert property (ce && encEdge && countUp && !measEnd |=>
        pulseCount_q == $past(pulseCount_q) + 1)
        else $error("encoder pulse not counted");

    assign absCount = pulseCount_q[31] ? 32'(-pulseCount_q) : 32'(pulseCount_q);
    assign speedDiv.start = measEnd;
    assign speedDiv.dividend = 32'(absCount * RPM_FACTOR);
    assign speedDiv.divisor = {23'h000000, encSteps_q};

    // a window shorter than the divider drops that result; default is far longer
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            speedNeg_q <= 1'b0;
            speed_q <= 32'sh0;
        end
        else if (ce)
        begin
            if (measEnd && !speedDiv.busy)
                speedNeg_q <= pulseCount_q[31];
            if (speedDiv.done)
                speed_q <= speedNeg_q ? -$signed(speedDiv.quotient) :
                    $signed(speedDiv.quotient);
        end
    end

    a_speed_sign: assert property (ce && speedDiv.done && speedNeg_q |=> speed_q <= 0)
        else $error("reverse rotation reported positive");

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            emRevBrake <= 1'b0;
        else if (ce)
            emRevBrake <= emergencyReverse && (speed_q > 0);
    end

    a_emrev: assert property (ce && emergencyReverse && speed_q > 0 |=> emRevBrake)
        else $error("emergency reverse missed forward motion");

    // ramp time recomputed continuously as accel time times limit over top speed
    assign rampDiv.start = !rampDiv.busy && !rampDiv.done;
    assign rampDiv.dividend = {16'h0000, accelTime_q} * {16'h0000, speedLimit_q};
    assign rampDiv.divisor = {16'h0000, topSpeed_q};

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rampTimeMs <= ACCEL_TIME_RST;
        else if (ce && rampDiv.done)
            rampTimeMs <= (rampDiv.quotient[31:16] != 16'h0000) ? 16'hFFFF :
                rampDiv.quotient[15:0];
    end

    a_ramp_scale: assert property (ce && rampDiv.done && rampDiv.quotient < 32'h0001_0000 |=>
        rampTimeMs == $past(rampDiv.quotient[15:0]))
        else $error("scaled ramp time not taken");

    always_comb
    begin
        readHit = 1'b1;
        unique case (s_axi_araddr)
            ADDR_TOP_SPEED: readData = {16'h0000, topSpeed_q};
            ADDR_OPTION3: readData = optionWord_q;
            ADDR_ENC_STEPS: readData = {23'h000000, encSteps_q};
            ADDR_ACCEL_TIME: readData = {16'h0000, accelTime_q};
            ADDR_SPEED_LIMIT: readData = {16'h0000, speedLimit_q};
            ADDR_RAMP_TIME: readData = {16'h0000, rampTimeMs};
            ADDR_STATUS: readData = {16'h0000, faultCode, 5'h00, emRevBrake, drivePowered,
                paramFault};
            ADDR_POSITION: readData = position_q;
            ADDR_SPEED: readData = speed_q;
            default:
            begin
                readData = 32'h0000_0000;
                readHit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= readData;
                s_axi_rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ==== verif/shaft_encoder_model.sv ====
// shaft encoder model: pulse train on encA, rotation sense level on encB
`timescale 1ns/10ps
module shaft_encoder_model #(
    parameter int PERIOD = 25
) (
    input wire logic clk,
    input wire logic run,
    input wire logic reverse,
    output logic encA,
    output logic encB
);
    int cnt;
    // restarts with run, so n periods of run give exactly n rising edges
    always_ff @(posedge clk)
    begin
        if (!run)
            cnt <= 0;
        else
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    end
    // low for more than one cycle between edges, as the counter needs
    assign encA = run && (cnt < PERIOD / 2);
    assign encB = reverse;
endmodule

// ==== verif/motor_encoder_setup_test.sv ====
// self-checking bench of the motor encoder setup block
`timescale 1ns/10ps
module motor_encoder_setup_test;
    import motor_setup_pkg::*;
    localparam int WIN = 200;
    localparam int PER = 25;
    logic clk = 1'b0, resetn = 1'b0, ce = 1'b1;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic [31:0] wData = 32'h0;
    logic [3:0] wStrb = 4'h0;
    logic awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp;
    logic [31:0] rData, pos0, pos1;
    logic encA, encB, run = 1'b0, reverse = 1'b0;
    logic cmdA = 1'b0, cmdB = 1'b0, cmdC = 1'b0, powered = 1'b0, emRev = 1'b0;
    logic phaseOutA, phaseOutB, phaseOutC, paramFault, emRevBrake;
    logic [7:0] faultCode;
    logic [15:0] rampTimeMs;
    int n_fail = 0, check_count = 0, cycles = 0;
    logic [31:0] lims [2] = '{32'h0BB8, 32'h03E8};
    logic [31:0] ramps [2] = '{32'h05DC, 32'h01F4};

    always #5 clk = ~clk;

    motor_encoder_setup #(.MEAS_CYCLES_P(WIN)) uut (.clk(clk), .resetn(resetn), .ce(ce),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
        .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady), .encA(encA), .encB(encB),
        .phaseCmdA(cmdA), .phaseCmdB(cmdB), .phaseCmdC(cmdC), .drivePowered(powered),
        .emergencyReverse(emRev), .phaseOutA(phaseOutA), .phaseOutB(phaseOutB),
        .phaseOutC(phaseOutC), .paramFault(paramFault), .faultCode(faultCode),
        .emRevBrake(emRevBrake), .rampTimeMs(rampTimeMs));

    shaft_encoder_model #(.PERIOD(PER)) encoder (.clk(clk), .run(run), .reverse(reverse),
        .encA(encA), .encB(encB));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic powerCycle();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit awDone, wDone;
        awDone = 0;
        wDone = 0;
        @(posedge clk);
        awAddr <= a;
        awValid <= 1'b1;
        wData <= d;
        wStrb <= 4'hF;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(awDone && wDone))
        begin
            @(posedge clk);
            if (!awDone && awReady === 1'b1)
            begin
                awDone = 1;
                awValid <= 1'b0;
            end
            if (!wDone && wReady === 1'b1)
            begin
                wDone = 1;
                wValid <= 1'b0;
            end
        end
        do @(posedge clk); while (bValid !== 1'b1);
        bReady <= 1'b0;
        check({30'h0, bResp}, {30'h0, er});
    endtask

    task automatic readReg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge clk); while (arReady !== 1'b1);
        arValid <= 1'b0;
        while (rValid !== 1'b1) @(posedge clk);
        d = rData;
        r = rResp;
        rReady <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        readReg(a, d, r);
        check(d, ed);
        check({30'h0, r}, {30'h0, er});
    endtask

    // position change over n encoder pulses
    task automatic burst(input int n, output logic [31:0] delta);
        logic [1:0] r;
        readReg(ADDR_POSITION, pos0, r);
        run <= 1'b1;
        repeat (n * PER) @(posedge clk);
        run <= 1'b0;
        repeat (4) @(posedge clk);
        readReg(ADDR_POSITION, pos1, r);
        delta = pos1 - pos0;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    initial
    begin
        logic [31:0] delta;
        powerCycle();
        check({16'h0, rampTimeMs}, 32'h0BB8);
        rd(ADDR_TOP_SPEED, 32'h1770, RESP_OKAY);
        rd(ADDR_OPTION3, 32'h0, RESP_OKAY);
        rd(ADDR_ENC_STEPS, 32'h40, RESP_OKAY);
        rd(ADDR_ACCEL_TIME, 32'h0BB8, RESP_OKAY);
        rd(ADDR_SPEED_LIMIT, 32'h1770, RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'h1, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h1, RESP_OKAY);
        wr(ADDR_TOP_SPEED, 32'h64, RESP_OKAY);
        rd(ADDR_TOP_SPEED, 32'h01F4, RESP_OKAY);
        wr(ADDR_TOP_SPEED, 32'h2328, RESP_OKAY);
        rd(ADDR_TOP_SPEED, 32'h1F40, RESP_OKAY);
        wr(ADDR_TOP_SPEED, 32'h1770, RESP_OKAY);
        wr(ADDR_OPTION3, 32'h0, RESP_OKAY);
        for (int i = 0; i < 2; i++)
        begin
            wr(ADDR_SPEED_LIMIT, lims[i], RESP_OKAY);
            // divider may have just latched the old limit: up to two passes
            repeat (80) @(posedge clk);
            check({16'h0, rampTimeMs}, ramps[i]);
            rd(ADDR_RAMP_TIME, ramps[i], RESP_OKAY);
        end
        check({31'h0, paramFault}, 32'h0);
        burst(5, delta);
        check(delta, 32'h5);
        // pulses arriving while the clock enable is low must not count
        ce <= 1'b0;
        run <= 1'b1;
        repeat (100) @(posedge clk);
        run <= 1'b0;
        ce <= 1'b1;
        rd(ADDR_POSITION, pos1, RESP_OKAY);
        // forward rotation kept on encB low so speed reads positive
        run <= 1'b1;
        repeat (500) @(posedge clk);
        rd(ADDR_SPEED, 32'h4B, RESP_OKAY);
        emRev <= 1'b1;
        repeat (3) @(posedge clk);
        check({31'h0, emRevBrake}, 32'h1);
        reverse <= 1'b1;
        repeat (500) @(posedge clk);
        rd(ADDR_SPEED, 32'hFFFFFFB5, RESP_OKAY);
        check({31'h0, emRevBrake}, 32'h0);
        run <= 1'b0;
        emRev <= 1'b0;
        reverse <= 1'b0;
        cmdA <= 1'b1;
        cmdC <= 1'b1;
        repeat (3) @(posedge clk);
        check({29'h0, phaseOutA, phaseOutB, phaseOutC}, 32'h5);
        // motor unpowered while safety settings change
        wr(ADDR_OPTION3, 32'h8, RESP_OKAY);
        repeat (3) @(posedge clk);
        check({29'h0, phaseOutA, phaseOutB, phaseOutC}, 32'h6);
        check({31'h0, paramFault}, 32'h1);
        check({24'h0, faultCode}, 32'h31);
        powered <= 1'b1;
        rd(ADDR_STATUS, 32'h3103, RESP_OKAY);
        powered <= 1'b0;
        powerCycle();
        check({31'h0, paramFault}, 32'h0);
        wr(ADDR_OPTION3, 32'h1, RESP_OKAY);
        repeat (2) @(posedge clk);
        check({31'h0, paramFault}, 32'h1);
        burst(5, delta);
        check(delta, 32'hFFFFFFFB);
        powerCycle();
        wr(ADDR_ENC_STEPS, 32'h12C, RESP_OKAY);
        rd(ADDR_ENC_STEPS, 32'h100, RESP_OKAY);
        // resolution set to the low end for the attached model
        wr(ADDR_ENC_STEPS, 32'hA, RESP_OKAY);
        rd(ADDR_ENC_STEPS, 32'h20, RESP_OKAY);
        check({31'h0, paramFault}, 32'h1);
        run <= 1'b1;
        repeat (500) @(posedge clk);
        rd(ADDR_SPEED, 32'h96, RESP_OKAY);
        tally_and_finish();
    end
endmodule
